// ===== rtl/alarm_pkg.sv
// alarm_pkg: constants, register map and types of the limit-alarm evaluator
// assumes one 125 MHz clock and a 32-bit classic Wishbone register bus
// Notes on behaviour
// - each alarm holds a programmable limit level
// - falling alarms trigger below level minus hysteresis
// - falling alarms clear above level plus hysteresis
// - rising alarms trigger above level plus hysteresis
// - rising alarms clear below level minus hysteresis
// - assert only after trigger persists for delay
// - clear only after release persists for delay
// - asserted alarm stays on minimum on time
// - cleared alarm stays off minimum off time
// - summary is OR of selected alarms
// - summary channel 21 has enable mode
// - per-alarm mask selects summary sources 5-20
// - tone set by summary, held until acknowledge
// - alarms default to their own measurement input
// - alarm state reads 0 inactive, 1 active
package alarm_pkg;
    localparam int VALUE_W    = 16;
    localparam int TIME_W     = 16;
    localparam int N_MEAS     = 4;
    localparam int N_ALARM    = 16;
    localparam int KINDS      = 4;
    localparam int ADR_W      = 12;
    localparam int IRQ_W      = N_ALARM + 3;
    localparam int FIRST_ALARM_CHANNEL = 5;
    localparam int SUMMARY_CHANNEL     = 21;
    // alarm kinds: bit 1 set means the alarm watches a rising value
    localparam logic [1:0] FALLING_CRITICAL = 2'h0;
    localparam logic [1:0] FALLING_WARNING  = 2'h1;
    localparam logic [1:0] RISING_WARNING   = 2'h2;
    localparam logic [1:0] RISING_CRITICAL  = 2'h3;
    localparam logic [ADR_W-1:0] ADDR_CTRL       = 12'h000;
    localparam logic [ADR_W-1:0] ADDR_SELECT     = 12'h004;
    localparam logic [ADR_W-1:0] ADDR_STATE      = 12'h008;
    localparam logic [ADR_W-1:0] ADDR_IRQ_STATUS = 12'h00c;
    localparam logic [ADR_W-1:0] ADDR_IRQ_MASK   = 12'h010;
    localparam logic [ADR_W-1:0] ADDR_TICK_DIV   = 12'h014;
    localparam logic [ADR_W-1:0] ADDR_ALARM_BASE = 12'h100;
    localparam logic [ADR_W-1:0] ADDR_ALARM_END  = 12'h300;
    localparam int ALARM_IDX_LSB = 5;
    localparam int FIELD_LSB     = 2;
    localparam logic [2:0] FIELD_LEVEL   = 3'h0;
    localparam logic [2:0] FIELD_HYST    = 3'h1;
    localparam logic [2:0] FIELD_ON_DLY  = 3'h2;
    localparam logic [2:0] FIELD_OFF_DLY = 3'h3;
    localparam logic [2:0] FIELD_MIN_ON  = 3'h4;
    localparam logic [2:0] FIELD_MIN_OFF = 3'h5;
    localparam logic [2:0] FIELD_SOURCE  = 3'h6;
    localparam int CTRL_SUMMARY_EN = 0;
    localparam int CTRL_ACK        = 1;
    localparam int IRQ_SUMMARY_ON  = N_ALARM;
    localparam int IRQ_SUMMARY_OFF = N_ALARM + 1;
    localparam int IRQ_ACK         = N_ALARM + 2;
    localparam int STATE_SUMMARY   = N_ALARM;
    localparam int STATE_TONE      = N_ALARM + 1;
    localparam logic              SUMMARY_EN_RESET = 1'b1;
    localparam logic [N_ALARM-1:0] SELECT_RESET    = 16'hffff;
    localparam int CLK_PERIOD_NS  = 8;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
    typedef struct packed {
        logic [VALUE_W-1:0] level;
        logic [VALUE_W-1:0] hyst;
        logic [TIME_W-1:0]  on_dly;
        logic [TIME_W-1:0]  off_dly;
        logic [TIME_W-1:0]  min_on;
        logic [TIME_W-1:0]  min_off;
        logic [1:0]         source;
    } alarm_cfg_type;
    typedef enum logic {
        ALARM_OFF = 1'b0,
        ALARM_ON  = 1'b1
    } alarm_phase_type;
endpackage : alarm_pkg

// ===== rtl/alarm_if.sv
// alarm_if: one alarm's config, input value and result
// assumes the owner drives cfg, value, kind and tick synchronously to clk
`timescale 1ns/1ps
`default_nettype none
interface alarm_if;
    import alarm_pkg::*;
    logic signed [VALUE_W-1:0] value;
    alarm_cfg_type             cfg;
    logic [1:0]                kind;
    logic                      tick;
    logic                      active;
    modport evaluator (input value, cfg, kind, tick, output active);
    modport owner     (output value, cfg, kind, tick, input active);
endinterface : alarm_if
`default_nettype wire

// ===== rtl/alarm_channel.sv
// alarm_channel: hysteresis comparator with on/off delay and min times
// assumes the tick pulse is one cycle wide and config is stable
`timescale 1ns/1ps
`default_nettype none
module alarm_channel (
    input wire logic    clk,   // system clock
    input wire logic    rst_n, // async reset, active low
    alarm_if.evaluator  link   // config in, alarm state out
);
    import alarm_pkg::*;
    typedef struct packed {
        alarm_phase_type     phase;
        logic [TIME_W-1:0]   dwell;
        logic [TIME_W-1:0]   hold;
    } chan_type;
    chan_type cur;
    chan_type next_cur;
    logic signed [VALUE_W+1:0] val;
    logic signed [VALUE_W+1:0] upper;
    logic signed [VALUE_W+1:0] lower;
    logic above;
    logic below;
    logic trig;
    logic rls;
    logic on_ready;
    logic off_ready;
    always_comb
    begin
        val   = (VALUE_W+2)'(link.value);
        upper = (VALUE_W+2)'($signed(link.cfg.level))
              + $signed({2'h0, link.cfg.hyst});
        lower = (VALUE_W+2)'($signed(link.cfg.level))
              - $signed({2'h0, link.cfg.hyst});
        above = val > upper;
        below = val < lower;
        trig  = link.kind[1] ? above : below;
        rls   = link.kind[1] ? below : above;
        on_ready  = cur.dwell >= link.cfg.on_dly;
        off_ready = cur.dwell >= link.cfg.off_dly;
        next_cur = cur;
        if (link.tick && cur.hold != '0)
        begin
            next_cur.hold = cur.hold - 1'b1;
        end
        case (cur.phase)
            ALARM_OFF:
            begin
                if (!trig)
                begin
                    next_cur.dwell = '0;
                end
                else if (on_ready && cur.hold == '0)
                begin
                    next_cur.phase = ALARM_ON;
                    next_cur.dwell = '0;
                    next_cur.hold  = link.cfg.min_on;
                end
                else if (link.tick && !on_ready)
                begin
                    next_cur.dwell = cur.dwell + 1'b1;
                end
            end
            default:
            begin
                if (!rls)
                begin
                    next_cur.dwell = '0;
                end
                else if (off_ready && cur.hold == '0)
                begin
                    next_cur.phase = ALARM_OFF;
                    next_cur.dwell = '0;
                    next_cur.hold  = link.cfg.min_off;
                end
                else if (link.tick && !off_ready)
                begin
                    next_cur.dwell = cur.dwell + 1'b1;
                end
            end
        endcase
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            cur <= '0;
        else
            cur <= next_cur;
    end
    assign link.active = (cur.phase == ALARM_ON);
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_FALL_TRIGGER: assert property ($rose(link.active) && !link.kind[1]
        |-> $past(below)) else $error("falling alarm set without low");
    AST_FALL_CLEAR: assert property ($fell(link.active) && !link.kind[1]
        |-> $past(above)) else $error("falling alarm cleared early");
    AST_RISE_TRIGGER: assert property ($rose(link.active) && link.kind[1]
        |-> $past(above)) else $error("rising alarm set without high");
    AST_RISE_CLEAR: assert property ($fell(link.active) && link.kind[1]
        |-> $past(below)) else $error("rising alarm cleared early");
    AST_ON_DELAY: assert property ($rose(link.active) |-> $past(on_ready))
        else $error("alarm set before on delay");
    AST_OFF_DELAY: assert property ($fell(link.active) |-> $past(off_ready))
        else $error("alarm cleared before off delay");
    AST_MIN_ON: assert property ($fell(link.active) |-> $past(cur.hold) == '0)
        else $error("alarm cleared inside min on time");
    AST_MIN_OFF: assert property ($rose(link.active) |-> $past(cur.hold) == '0)
        else $error("alarm set inside min off time");
    COV_ALARM_SET: cover property ($rose(link.active));
    COV_ALARM_CLEAR: cover property ($fell(link.active));
endmodule : alarm_channel
`default_nettype wire

// ===== rtl/alarm_hysteresis_evaluator.sv
// alarm_hysteresis_evaluator: sixteen limit alarms, summary alarm and tone
// assumes measured values and acknowledge are synchronous to clk
//
// Decided for this implementation: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module alarm_hysteresis_evaluator #(
    parameter int TICK_CYCLES_P = alarm_pkg::TICK_CYCLES
) (
    input  wire logic                    clk,           // 125 MHz clock
    input  wire logic                    rst_n,         // async reset
    input  wire logic                    wb_cyc_i,      // bus cycle
    input  wire logic                    wb_stb_i,      // strobe
    input  wire logic                    wb_we_i,       // write enable
    input  wire logic [alarm_pkg::ADR_W-1:0] wb_adr_i,  // byte address
    input  wire logic [31:0]             wb_dat_i,      // write data
    input  wire logic [3:0]              wb_sel_i,      // byte lanes
    output logic [31:0]                  wb_dat_o,      // read data
    output logic                         wb_ack_o,      // answer
    input  wire logic [alarm_pkg::N_MEAS-1:0][alarm_pkg::VALUE_W-1:0]
                                         meas_value,    // measured inputs
    input  wire logic                    ack_in,        // operator ack
    output logic [alarm_pkg::N_ALARM-1:0] alarm_state,  // per alarm state
    output logic                         summary_alarm, // summary state
    output logic                         tone,          // warning tone
    output logic                         irq            // interrupt level
);
    import alarm_pkg::*;
    localparam int TC_W = $clog2(TICK_CYCLES_P + 1);
    localparam logic [TC_W-1:0] TICK_DIV_RESET = TC_W'(TICK_CYCLES_P - 1);
    typedef struct packed {
        alarm_cfg_type [N_ALARM-1:0] cfg;
        logic [N_ALARM-1:0]          select;
        logic                        summary_en;
        logic [IRQ_W-1:0]            irq_status;
        logic [IRQ_W-1:0]            irq_mask;
        logic [TC_W-1:0]             tick_div;
        logic [TC_W-1:0]             tick_cnt;
        logic                        tick;
        logic [N_ALARM-1:0]          alarms_q;
        logic                        summary;
        logic                        tone;
        logic [31:0]                 rdata;
        logic                        ack;
    } core_type;
    ////////////////////////////////////////////////////////////////////////
    // reset image; every alarm watches its own channel at first
    function automatic core_type reset_image();
        core_type r;
        r = '0;
        for (int i = 0; i < N_ALARM; i++)
        begin
            r.cfg[i].source = 2'(i / KINDS);
        end
        r.select     = SELECT_RESET;
        r.summary_en = SUMMARY_EN_RESET;
        r.tick_div   = TICK_DIV_RESET;
        return r;
    endfunction : reset_image
    localparam core_type RESET_IMAGE = reset_image();
    function automatic logic alarm_hit(input logic [ADR_W-1:0] adr);
        return adr >= ADDR_ALARM_BASE && adr < ADDR_ALARM_END;
    endfunction : alarm_hit
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wr,
                                          input logic [3:0]  sel);
        logic [31:0] m;
        m = old;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
                m[8*b +: 8] = wr[8*b +: 8];
        end
        return m;
    endfunction : merge
    function automatic logic [31:0] cfg_field(input alarm_cfg_type c,
                                              input logic [2:0]    f);
        logic [31:0] v;
        v = '0;
        case (f)
            FIELD_LEVEL:   v[VALUE_W-1:0] = c.level;
            FIELD_HYST:    v[VALUE_W-1:0] = c.hyst;
            FIELD_ON_DLY:  v[TIME_W-1:0]  = c.on_dly;
            FIELD_OFF_DLY: v[TIME_W-1:0]  = c.off_dly;
            FIELD_MIN_ON:  v[TIME_W-1:0]  = c.min_on;
            FIELD_MIN_OFF: v[TIME_W-1:0]  = c.min_off;
            FIELD_SOURCE:  v[1:0]         = c.source;
            default:       v = '0;
        endcase
        return v;
    endfunction : cfg_field
    ////////////////////////////////////////////////////////////////////////
    core_type           cur;
    core_type           next_cur;
    logic [N_ALARM-1:0] alarm_vec;
    logic [N_ALARM-1:0] sel_vec;
    logic               req;
    logic               wr_now;
    logic [ADR_W-1:0]   off;
    logic [3:0]         idx;
    logic [2:0]         field;
    logic [31:0]        wmerged;
    logic [31:0]        rd;
    logic               sum_now;
    logic               sum_rise;
    logic               sum_fall;
    logic               sw_ack;
    logic               ack_any;
    logic [IRQ_W-1:0]   events;
    logic [IRQ_W-1:0]   w1c;
    alarm_if lnk [N_ALARM] ();
    genvar g;
    generate
        for (g = 0; g < N_ALARM; g++)
        begin : g_alarm
            assign lnk[g].value = meas_value[cur.cfg[g].source];
            assign lnk[g].cfg   = cur.cfg[g];
            assign lnk[g].kind  = 2'(g % KINDS);
            assign lnk[g].tick  = cur.tick;
            assign alarm_vec[g] = lnk[g].active;
            alarm_channel u_chan (
                .clk   (clk),
                .rst_n (rst_n),
                .link  (lnk[g])
            );
        end
    endgenerate
    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_cur = cur;
        req    = wb_cyc_i && wb_stb_i;
        wr_now = req && wb_we_i && cur.ack;
        off    = wb_adr_i - ADDR_ALARM_BASE;
        idx    = off[ALARM_IDX_LSB +: 4];
        field  = off[FIELD_LSB +: 3];
        rd     = '0;
        w1c    = '0;
        sw_ack = 1'b0;
        // register read mux
        if (wb_adr_i == ADDR_CTRL)
        begin
            rd[CTRL_SUMMARY_EN] = cur.summary_en;
        end
        else if (wb_adr_i == ADDR_SELECT)
        begin
            rd[N_ALARM-1:0] = cur.select;
        end
        else if (wb_adr_i == ADDR_STATE)
        begin
            rd[N_ALARM-1:0]   = cur.alarms_q;
            rd[STATE_SUMMARY] = cur.summary;
            rd[STATE_TONE]    = cur.tone;
        end
        else if (wb_adr_i == ADDR_IRQ_STATUS)
        begin
            rd[IRQ_W-1:0] = cur.irq_status;
        end
        else if (wb_adr_i == ADDR_IRQ_MASK)
        begin
            rd[IRQ_W-1:0] = cur.irq_mask;
        end
        else if (wb_adr_i == ADDR_TICK_DIV)
        begin
            rd[TC_W-1:0] = cur.tick_div;
        end
        else if (alarm_hit(wb_adr_i))
        begin
            rd = cfg_field(cur.cfg[idx], field);
        end
        wmerged = merge(rd, wb_dat_i, wb_sel_i);
        // register writes, taken in the ack cycle
        if (wr_now)
        begin
            if (wb_adr_i == ADDR_CTRL)
            begin
                next_cur.summary_en = wmerged[CTRL_SUMMARY_EN];
                sw_ack = wb_sel_i[0] && wb_dat_i[CTRL_ACK];
            end
            else if (wb_adr_i == ADDR_SELECT)
            begin
                next_cur.select = wmerged[N_ALARM-1:0];
            end
            else if (wb_adr_i == ADDR_IRQ_STATUS)
            begin
                w1c = wmerged[IRQ_W-1:0] & IRQ_W'({{8{wb_sel_i[3]}},
                      {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}});
            end
            else if (wb_adr_i == ADDR_IRQ_MASK)
            begin
                next_cur.irq_mask = wmerged[IRQ_W-1:0];
            end
            else if (wb_adr_i == ADDR_TICK_DIV)
            begin
                next_cur.tick_div = wmerged[TC_W-1:0];
            end
            else if (alarm_hit(wb_adr_i))
            begin
                case (field)
                    FIELD_LEVEL:
                        next_cur.cfg[idx].level = wmerged[VALUE_W-1:0];
                    FIELD_HYST:
                        next_cur.cfg[idx].hyst = wmerged[VALUE_W-1:0];
                    FIELD_ON_DLY:
                        next_cur.cfg[idx].on_dly = wmerged[TIME_W-1:0];
                    FIELD_OFF_DLY:
                        next_cur.cfg[idx].off_dly = wmerged[TIME_W-1:0];
                    FIELD_MIN_ON:
                        next_cur.cfg[idx].min_on = wmerged[TIME_W-1:0];
                    FIELD_MIN_OFF:
                        next_cur.cfg[idx].min_off = wmerged[TIME_W-1:0];
                    FIELD_SOURCE:
                        next_cur.cfg[idx].source = wmerged[1:0];
                    default:
                        next_cur.cfg[idx].source = cur.cfg[idx].source;
                endcase
            end
        end
        // bus answer one cycle after the request, dropped the next
        next_cur.ack = req && !cur.ack;
        if (req && !cur.ack)
            next_cur.rdata = rd;
        // timebase shared by every alarm
        next_cur.tick = 1'b0;
        if (cur.tick_cnt >= cur.tick_div)
        begin
            next_cur.tick_cnt = '0;
            next_cur.tick     = 1'b1;
        end
        else
        begin
            next_cur.tick_cnt = cur.tick_cnt + 1'b1;
        end
        // summary alarm and tone
        sel_vec  = alarm_vec & cur.select;
        sum_now  = cur.summary_en && (|sel_vec);
        sum_rise = sum_now && !cur.summary;
        sum_fall = !sum_now && cur.summary;
        ack_any  = ack_in || sw_ack;
        next_cur.summary  = sum_now;
        next_cur.alarms_q = alarm_vec;
        next_cur.tone = sum_rise || (cur.tone && !ack_any);
        // sticky events, a new event wins over its clear
        events = '0;
        events[N_ALARM-1:0]     = alarm_vec & ~cur.alarms_q;
        events[IRQ_SUMMARY_ON]  = sum_rise;
        events[IRQ_SUMMARY_OFF] = sum_fall;
        events[IRQ_ACK]         = ack_any && cur.tone;
        next_cur.irq_status = (cur.irq_status & ~w1c) | events;
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            cur <= RESET_IMAGE;
        else
            cur <= next_cur;
    end
    ////////////////////////////////////////////////////////////////////////
    assign wb_dat_o      = cur.rdata;
    assign wb_ack_o      = cur.ack;
    assign alarm_state   = cur.alarms_q;
    assign summary_alarm = cur.summary;
    assign tone          = cur.tone;
    assign irq           = |(cur.irq_status & cur.irq_mask);
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_SUMMARY_OR: assert property (summary_alarm ==
        ($past(cur.summary_en) && $past(|sel_vec)))
        else $error("summary differs from selected alarms");
    AST_SUMMARY_OFF: assert property (!cur.summary_en ##1 !cur.summary_en
        |-> !summary_alarm) else $error("disabled summary active");
    AST_MASKED_OUT: assert property ((alarm_vec & ~cur.select) != '0
        && (alarm_vec & cur.select) == '0 |=> !summary_alarm)
        else $error("unselected alarm reached summary");
    AST_TONE_SET: assert property ($rose(summary_alarm) |-> tone)
        else $error("tone missing on summary rise");
    AST_TONE_HOLD: assert property (tone && !ack_in && !sw_ack
        |=> tone) else $error("tone dropped without ack");
    AST_TICK_PULSE: assert property (cur.tick && cur.tick_div != '0
        |=> !cur.tick) else $error("timebase tick too wide");
    AST_WB_ACK: assert property (req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus answer not one cycle");
    COV_SUMMARY: cover property ($rose(summary_alarm));
    COV_TONE_ACK: cover property (tone ##1 !tone);
    COV_WRITE_LEVEL: cover property (wr_now && alarm_hit(wb_adr_i)
        && field == FIELD_LEVEL);
endmodule : alarm_hysteresis_evaluator
`default_nettype wire

// ===== tb/alarm_source_model.sv
// alarm_source_model: measured value sources and operator acknowledge
// assumes the bench calls its tasks from one process
`timescale 1ns/1ps
`default_nettype none
module alarm_source_model (
    input  wire logic clk,  // system clock
    output logic [alarm_pkg::N_MEAS-1:0][alarm_pkg::VALUE_W-1:0]
                      meas_value, // measured inputs
    output logic      ack_in      // operator ack
);
    import alarm_pkg::*;
    initial
    begin
        meas_value = '0;
        ack_in = 1'b0;
    end
    task automatic set_value(input int ch, input logic [15:0] v);
        @(posedge clk);
        meas_value[ch] <= v;
    endtask : set_value
    task automatic press_ack();
        @(posedge clk);
        ack_in <= 1'b1;
        @(posedge clk);
        ack_in <= 1'b0;
    endtask : press_ack
endmodule : alarm_source_model
`default_nettype wire

// ===== tb/alarm_hysteresis_evaluator_tb.sv
// alarm_hysteresis_evaluator_tb: directed scenarios, bus and alarm ports
// assumes a tick every 4 clocks
`timescale 1ns/1ps
`default_nettype none
module alarm_hysteresis_evaluator_tb;
    import alarm_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [11:0] adr = '0;
    logic [31:0] dat = '0;
    logic [31:0] rd;
    logic [31:0] rdat;
    logic ack;
    logic [N_MEAS-1:0][VALUE_W-1:0] meas;
    logic ack_in;
    logic [15:0] st;
    logic summ;
    logic tone;
    logic irq;
    wire logic [18:0] obs = {irq, tone, summ, st};
    int bad_count = 0;
    int samples_checked = 0;
    always #4 clk = ~clk;
    alarm_hysteresis_evaluator #(.TICK_CYCLES_P(4)) dut_u (.clk(clk),
        .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hf), .wb_dat_o(rd),
        .wb_ack_o(ack), .meas_value(meas), .ack_in(ack_in),
        .alarm_state(st), .summary_alarm(summ), .tone(tone), .irq(irq));
    alarm_source_model src_u (.clk(clk), .meas_value(meas),
        .ack_in(ack_in));
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1)
            bad_count++;
        rdat = rd;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(rdat, e);
    endtask : rdchk
    // bounded wait for an output bit
    task automatic wait_bit(input int i, input logic e, input int n);
        repeat (n)
        begin
            @(negedge clk);
            if (obs[i] === e)
                break;
        end
        chk({31'h0, obs[i]}, {31'h0, e});
    endtask : wait_bit
    task automatic hold_bit(input int i, input logic e, input int n);
        repeat (n) @(negedge clk);
        chk({31'h0, obs[i]}, {31'h0, e});
    endtask : hold_bit
    ////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rdchk(ADDR_CTRL, 32'h1);
        rdchk(ADDR_SELECT, 32'hffff);
        rdchk(12'h020, 32'h0);
        rdchk(12'h1b8, 32'h1);
        wb(1'b1, ADDR_ALARM_BASE, 32'hff9c);
        wb(1'b1, 12'h104, 32'ha);
        rdchk(ADDR_ALARM_BASE, 32'hff9c);
    endtask : t_regs
    task automatic t_falling();
        src_u.set_value(0, 16'hff97);
        hold_bit(0, 1'b0, 12);
        src_u.set_value(0, 16'hff8d);
        wait_bit(0, 1'b1, 10);
        src_u.set_value(0, 16'hffa1);
        hold_bit(0, 1'b1, 12);
        src_u.set_value(0, 16'hffab);
        wait_bit(0, 1'b0, 10);
    endtask : t_falling
    task automatic t_rising();
        wb(1'b1, 12'h160, 32'h64);
        wb(1'b1, 12'h164, 32'ha);
        wb(1'b1, 12'h168, 32'h3);
        wb(1'b1, 12'h170, 32'hc);
        wb(1'b1, 12'h174, 32'hc);
        src_u.set_value(0, 16'h0069);
        hold_bit(3, 1'b0, 12);
        src_u.set_value(0, 16'h0078);
        hold_bit(3, 1'b0, 6);
        wait_bit(3, 1'b1, 30);
        src_u.set_value(0, 16'h005f);
        hold_bit(3, 1'b1, 12);
        src_u.set_value(0, 16'h0050);
        hold_bit(3, 1'b1, 8);
        wait_bit(3, 1'b0, 60);
        src_u.set_value(0, 16'h0078);
        hold_bit(3, 1'b0, 20);
        wait_bit(3, 1'b1, 60);
    endtask : t_rising
    task automatic t_summary();
        wb(1'b1, ADDR_SELECT, 32'h0);
        wait_bit(16, 1'b0, 6);
        src_u.press_ack();
        wait_bit(17, 1'b0, 6);
        wb(1'b1, ADDR_IRQ_MASK, 32'h10000);
        wb(1'b1, ADDR_IRQ_STATUS, 32'h7ffff);
        hold_bit(18, 1'b0, 2);
        wb(1'b1, ADDR_SELECT, 32'h8);
        wait_bit(16, 1'b1, 6);
        wait_bit(17, 1'b1, 4);
        wait_bit(18, 1'b1, 4);
        hold_bit(17, 1'b1, 10);
        wb(1'b1, ADDR_CTRL, 32'h0);
        wait_bit(16, 1'b0, 6);
        wb(1'b1, ADDR_IRQ_STATUS, 32'h10000);
        wait_bit(18, 1'b0, 6);
    endtask : t_summary
    task automatic results();
        if (bad_count == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : results
    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_falling();
        t_rising();
        t_summary();
        results();
    end
    initial
    begin
        repeat (5000) @(posedge clk);
        bad_count++;
        results();
    end
endmodule : alarm_hysteresis_evaluator_tb
`default_nettype wire
